/* File: hw/bus_mc_log.sv */
// module: machine-check log bank for shared cache and system bus errors
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1 - prescale timer steps every 128 bus clocks
// RULE2 - bus clock is core over 2, 3, 4
// RULE3 - timer carry adds one to time-out counter
// RULE4 - time-out flag locks the logged entry
// RULE5 - bit 42 hard error, locks entry
// RULE6 - bit 43 internal failure, locks entry
// RULE7 - bank 4 status is main log
// RULE8 - correctable count lives in bits 56:32; code keeps a 10-bit count in 56:47
// RULE9 - internal error code is 0x0400
// RULE10 - bus error code is 0x0E0F
// RULE11 - reserved bus codes never produced
// RULE12 - detail in 31:16, type in 15:0
// RULE13 - bit 16 request phase parity
// RULE14 - bit 20 hard fail response
// RULE15 - bit 21 response field parity
// RULE16 - bit 22 inbound data parity
// RULE17 - 23-bit counter, carry means time-out
// RULE18 - clear counter on retire/exception/reset/init
// RULE19 - reserved bits read zero, ignore writes
module bus_mc_log #(
    parameter int PRESCALE = mc_log_pkg::PRESCALE_DIV, // bus clocks per step
    parameter int TIMER_W  = mc_log_pkg::TIMER_W,      // prescale timer bits
    parameter int TMO_W    = mc_log_pkg::TMO_W         // time-out counter bits
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        instrRetired,
    input  wire logic        exceptionSeen,
    input  wire logic        internalFault,
    input  wire logic        busInitIn,
    input  wire logic        reqParPin,
    input  wire logic        hardFailPin,
    input  wire logic        rspParPin,
    input  wire logic        dataParPin,
    input  wire logic        corrPin,
    output logic             busClockOut,
    output logic             internalFailureOut,
    output logic             busInitSignal,
    output logic             irq
);
    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    // true when the byte address hits the given register
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    localparam int PIN_N = 6;            // pins from other bus agents
    logic [PIN_N-1:0] pinRaw;            // raw pins
    logic [PIN_N-1:0] sync1_r;           // first stage, read by stage two only
    logic [PIN_N-1:0] sync2_r;           // safe levels
    logic [PIN_N-1:0] prev_r;            // previous safe level
    logic [PIN_N-1:0] rise;              // rising edge pulses
    assign pinRaw = {busInitIn, corrPin, dataParPin, rspParPin, hardFailPin, reqParPin};

    genvar g;
    generate
        for (g = 0; g < PIN_N; g++) begin : gSync
            // two flops, then edge detect on the safe stage
            always_ff @(posedge clock or negedge nrst) begin
                if (!nrst) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    prev_r[g]  <= 1'b0;
                end else begin
                    sync1_r[g] <= pinRaw[g];
                    sync2_r[g] <= sync1_r[g];
                    prev_r[g]  <= sync2_r[g];
                end
            end
            assign rise[g] = sync2_r[g] & ~prev_r[g];
        end
    endgenerate

    mc_log_pkg::busEvt_t evt;            // bus events, one pulse each
    logic                busInitEvt;     // bus init seen from outside
    assign evt.reqPar   = rise[0];
    assign evt.hardFail = rise[1];
    assign evt.rspPar   = rise[2];
    assign evt.dataPar  = rise[3];
    assign evt.corr     = rise[4];
    assign busInitEvt   = rise[5];

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    logic [1:0] ratio_r;                 // bus clock ratio select
    logic       wrAcc;                   // write takes effect now
    logic       rdSetup;                 // setup cycle of any access
    assign wrAcc   = psel & penable & pready & pwrite;
    assign rdSetup = psel & ~penable;

    // ratio write; 0 is not a legal ratio and is ignored
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ratio_r <= mc_log_pkg::RATIO_RESET;
        end else if (wrAcc && hit(paddr, mc_log_pkg::OFF_CTRL) && pwdata[1:0] != 2'h0) begin
            ratio_r <= pwdata[1:0];
        end
    end

    // ---------------------------------------------------------------
    // bus clock divider
    // ---------------------------------------------------------------
    logic [1:0] divCnt_r;                // core clocks into this bus clock
    logic [1:0] divTop;                  // last count of a bus period
    logic       busTick;                 // one pulse per bus clock
    assign divTop  = ratio_r;            // 1:2 -> 0..1, 1:3 -> 0..2, 1:4 -> 0..3
    assign busTick = (divCnt_r >= divTop);

    // divide core clock, high for one core clock of each period
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            divCnt_r    <= 2'h0;
            busClockOut <= 1'b0;
        end else begin
            divCnt_r    <= busTick ? 2'h0 : divCnt_r + 2'h1; // RULE2
            busClockOut <= busTick;      // ratios other than 1:2 give uneven duty, accepted
        end
    end

    // ---------------------------------------------------------------
    // prescaler and retirement time-out
    // ---------------------------------------------------------------
    localparam int PRE_W = $clog2(PRESCALE);
    logic [PRE_W-1:0]   pre_r;           // bus clocks toward one step
    logic [TIMER_W-1:0] timer_r;         // prescale timer
    logic [TMO_W-1:0]   tmo_r;           // time-out counter
    logic               step;            // timer advances
    logic               timerCarry;      // carry out of the timer
    logic               tmoCarry;        // carry out of the counter
    logic               tmoClear;        // counter clear causes
    assign step       = busTick && (pre_r == PRE_W'(PRESCALE - 1));
    assign timerCarry = step && (&timer_r);
    assign tmoCarry   = timerCarry && (&tmo_r);
    assign tmoClear   = instrRetired | exceptionSeen | busInitEvt | busInitSignal; // RULE18

    // prescaler and timer run free from reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pre_r   <= '0;
            timer_r <= '0;
        end else begin
            if (busTick) begin
                pre_r <= step ? '0 : pre_r + PRE_W'(1); // RULE1
            end
            if (step) begin
                timer_r <= timer_r + TIMER_W'(1);         // RULE1
            end
        end
    end

    // counter: clears win over the carry, reset clears it too
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tmo_r <= '0;                 // RULE18
        end else if (tmoClear) begin
            tmo_r <= '0;                 // RULE18
        end else if (timerCarry) begin
            tmo_r <= tmo_r + TMO_W'(1);  // RULE3 RULE17
        end
    end

    // bus init pulse driven on time-out, also restarts counting
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busInitSignal <= 1'b0;
        end else begin
            busInitSignal <= tmoCarry && !tmoClear; // RULE17
        end
    end

    // ---------------------------------------------------------------
    // internal failure pin
    // ---------------------------------------------------------------
    logic logClear;                      // software clears the log
    assign logClear = wrAcc && hit(paddr, mc_log_pkg::OFF_CTRL) && pwdata[8];

    // pin holds from the fault until software clears the log
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            internalFailureOut <= 1'b0;
        end else if (internalFault) begin
            internalFailureOut <= 1'b1;
        end else if (logClear) begin
            internalFailureOut <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // status log
    // ---------------------------------------------------------------
    logic [63:0] stat_r;                 // cache_bus_error_status
    logic [63:0] stat_nxt;               // next log value
    logic        locked;                 // entry may not be overwritten
    logic        busErr;                 // any bus or interconnect error
    logic        intfNow;                // fault seen as pin goes active
    localparam int CNT_W_L = mc_log_pkg::CNT_W;
    logic [CNT_W_L-1:0] cnt;             // correctable count view
    assign intfNow = internalFault & ~internalFailureOut;
    assign busErr  = evt.reqPar | evt.hardFail | evt.rspPar | evt.dataPar;
    assign locked  = stat_r[mc_log_pkg::BIT_TMO] | stat_r[mc_log_pkg::BIT_HARD]
                   | stat_r[mc_log_pkg::BIT_INTF]; // RULE4 RULE5 RULE6
    assign cnt     = stat_r[mc_log_pkg::CNT_LSB +: CNT_W_L];

    // next value: internal failure over time-out over bus errors
    always_comb begin
        stat_nxt = stat_r;
        if (!locked) begin
            if (intfNow) begin
                stat_nxt = mc_log_pkg::STAT_RESET;
                stat_nxt[15:0] = mc_log_pkg::CODE_INTERNAL;           // RULE9 RULE12
                stat_nxt[mc_log_pkg::BIT_INTF] = 1'b1;                // RULE6
            end else if (busInitSignal) begin
                stat_nxt = mc_log_pkg::STAT_RESET;
                stat_nxt[15:0] = mc_log_pkg::CODE_INTERNAL;           // RULE9
                stat_nxt[mc_log_pkg::BIT_TMO] = 1'b1;                 // RULE4
            end else if (busErr) begin
                stat_nxt = mc_log_pkg::STAT_RESET;
                stat_nxt[15:0] = mc_log_pkg::CODE_BUS;                // RULE10 RULE11 RULE7
                stat_nxt[mc_log_pkg::BIT_REQP]  = evt.reqPar;         // RULE13
                stat_nxt[mc_log_pkg::BIT_HARDF] = evt.hardFail;       // RULE14
                stat_nxt[mc_log_pkg::BIT_RSPP]  = evt.rspPar;         // RULE15
                stat_nxt[mc_log_pkg::BIT_DATP]  = evt.dataPar;        // RULE16
                stat_nxt[mc_log_pkg::BIT_HARD]  = evt.hardFail;       // RULE5
            end
        end
        // the count survives a new entry and saturates
        stat_nxt[mc_log_pkg::CNT_LSB +: CNT_W_L] = cnt + CNT_W_L'(evt.corr && !(&cnt)); // RULE8
        if (logClear) begin
            stat_nxt = mc_log_pkg::STAT_RESET;
        end
    end

    // log register; only defined fields can ever become set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stat_r <= mc_log_pkg::STAT_RESET;
        end else begin
            stat_r <= stat_nxt;          // RULE19
        end
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    localparam int EN = mc_log_pkg::EVT_N;
    logic [EN-1:0] irqSt_r;              // sticky events
    logic [EN-1:0] irqMsk_r;             // enables
    logic [EN-1:0] irqSet;               // new events
    logic [EN-1:0] irqClr;               // software clears
    assign irqSet = {evt.corr, busErr, intfNow, busInitSignal, evt.hardFail};
    assign irqClr = (wrAcc && hit(paddr, mc_log_pkg::OFF_IRQ_ST)) ? pwdata[EN-1:0] : '0;

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irqSt_r <= '0;
        end else begin
            irqSt_r <= (irqSt_r & ~irqClr) | irqSet;
        end
    end

    // mask register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irqMsk_r <= '0;
        end else if (wrAcc && hit(paddr, mc_log_pkg::OFF_IRQ_MSK)) begin
            irqMsk_r <= pwdata[EN-1:0];
        end
    end

    // level output from a flop, one cycle behind the status
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqSt_r & irqMsk_r);
        end
    end

    // ---------------------------------------------------------------
    // apb read path
    // ---------------------------------------------------------------
    logic [31:0] rdMux;                  // read data for the address
    logic        mapped;                 // address is a register

    // reserved bits come through as zero
    always_comb begin
        rdMux  = 32'h0000_0000;
        mapped = 1'b1;
        if (hit(paddr, mc_log_pkg::OFF_STAT_LO)) begin
            rdMux = stat_r[31:0];
        end else if (hit(paddr, mc_log_pkg::OFF_STAT_HI)) begin
            rdMux = stat_r[63:32];      // RULE19
        end else if (hit(paddr, mc_log_pkg::OFF_CTRL)) begin
            rdMux[1:0] = ratio_r;
        end else if (hit(paddr, mc_log_pkg::OFF_TMO)) begin
            rdMux[TMO_W-1:0] = tmo_r;
        end else if (hit(paddr, mc_log_pkg::OFF_IRQ_ST)) begin
            rdMux[EN-1:0] = irqSt_r;
        end else if (hit(paddr, mc_log_pkg::OFF_IRQ_MSK)) begin
            rdMux[EN-1:0] = irqMsk_r;
        end else begin
            mapped = 1'b0;
        end
    end

    // no wait states: data and ready registered in the setup cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= rdSetup;
            pslverr <= rdSetup && !mapped;
            prdata  <= (rdSetup && !pwrite) ? rdMux : 32'h0000_0000;
        end
    end
endmodule : bus_mc_log
`default_nettype wire

/* File: hw/mc_log_pkg.sv */
// package: offsets, field layout, codes and types of the bus machine-check log
package mc_log_pkg;
    // ---------------------------------------------------------------
    // register byte offsets on the apb slave
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_STAT_LO = 8'h00; // log word, bits 31:0
    localparam logic [7:0] OFF_STAT_HI = 8'h04; // log word, bits 63:32
    localparam logic [7:0] OFF_CTRL    = 8'h08; // bus ratio, log clear
    localparam logic [7:0] OFF_TMO     = 8'h0C; // time-out counter view
    localparam logic [7:0] OFF_IRQ_ST  = 8'h10; // sticky events, w1c
    localparam logic [7:0] OFF_IRQ_MSK = 8'h14; // interrupt mask
    // ---------------------------------------------------------------
    // status field positions
    // ---------------------------------------------------------------
    localparam int ARCH_LSB  = 0;  // arch_error_code 15:0
    localparam int MODEL_LSB = 16; // model detail 31:16
    localparam int BIT_REQP  = 16; // request phase parity
    localparam int BIT_HARDF = 20; // hard fail response
    localparam int BIT_RSPP  = 21; // response field parity
    localparam int BIT_DATP  = 22; // inbound data parity
    localparam int BIT_TMO   = 38; // retirement time-out
    localparam int BIT_HARD  = 42; // hard error response
    localparam int BIT_INTF  = 43; // internal failure
    localparam int CNT_LSB   = 47; // correctable count 56:47
    localparam int CNT_W     = 10; // count width
    // ---------------------------------------------------------------
    // error codes and defaults
    // ---------------------------------------------------------------
    localparam logic [15:0] CODE_INTERNAL = 16'h0400;
    localparam logic [15:0] CODE_BUS      = 16'h0E0F;
    localparam logic [63:0] STAT_RESET    = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  RATIO_RESET   = 2'h1; // 1=1:2 2=1:3 3=1:4
    localparam int PRESCALE_DIV = 128; // bus clocks per timer step
    localparam int TIMER_W      = 8;   // prescale timer width
    localparam int TMO_W        = 23;  // time-out counter width
    localparam int EVT_N        = 5;   // interrupt event count
    // ---------------------------------------------------------------
    // event carrier
    // ---------------------------------------------------------------
    typedef struct packed {
        logic reqPar;   // request phase parity
        logic hardFail; // hard fail response, local transaction
        logic rspPar;   // response field parity
        logic dataPar;  // inbound data parity
        logic corr;     // correctable event
    } busEvt_t;
endpackage : mc_log_pkg

/* File: testbench/bus_mc_log_properties.sv */
// checker: concurrent properties watching the machine-check log ports
`timescale 1ns/1ps
`default_nettype none
module bus_mc_log_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        instrRetired,
    input wire logic        internalFault,
    input wire logic        busClockOut,
    input wire logic        internalFailureOut,
    input wire logic        busInitSignal
);
    // ------------------------------------------------------------
    // clocking and named steps
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    sequence setupPhase; // apb setup cycle, access not yet begun
        psel && !penable;
    endsequence
    sequence oneCycleAnswer; // answer stands for exactly one cycle
        pready ##1 !pready;
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_ready_one_wait: assert property (setupPhase |=> oneCycleAnswer)
        else $error("apb answer not exactly one cycle after setup");
    a_rdata_idle_zero: assert property (!pready |-> prdata == '0)
        else $error("read data not zero outside the answer cycle");
    a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == '0)
        else $error("unmapped access not refused with zero data");
    a_mapped_no_err: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped register access refused");
    a_fault_drives_pin: assert property (internalFault |=> internalFailureOut)
        else $error("internal failure output not raised after fault");
    a_init_one_pulse: assert property (busInitSignal |=> !busInitSignal)
        else $error("time-out init pulse longer than one cycle");
    a_retire_no_tmo: assert property (instrRetired |-> ##3 !busInitSignal [*8])
        else $error("time-out soon after a retirement");
    a_busclk_period: assert property (busClockOut |=> !busClockOut ##[1:3] busClockOut)
        else $error("bus clock period outside two to four core clocks");
endmodule : bus_mc_log_checker
bind bus_mc_log bus_mc_log_checker chk_i (
    .clock, .nrst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .instrRetired, .internalFault, .busClockOut, .internalFailureOut, .busInitSignal
);
`default_nettype wire

/* File: testbench/bus_agent_model.sv */
// partner: other system bus agents raising error pins toward the log
`timescale 1ns/1ps
`default_nettype none
module bus_agent_model (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire mc_log_pkg::busEvt_t  fire,
    output var  mc_log_pkg::busEvt_t  pins
);
    logic [1:0] holdCnt; // cycles a raised pin still stands
    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    // pins stand three cycles for the two-flop sync, then
    // fall low so each request gives one clean rising edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pins    <= '0;
            holdCnt <= 2'h0;
        end else if (fire != '0) begin // fresh request restarts the hold
            pins    <= fire;
            holdCnt <= 2'h2;
        end else if (holdCnt != 2'h0) begin
            holdCnt <= holdCnt - 2'h1;
        end else begin
            pins <= '0; // idle low between events
        end
    end
endmodule : bus_agent_model
`default_nettype wire

/* File: testbench/bus_mc_log_tb.sv */
// testbench: self-checking bench of the bus machine-check log
`timescale 1ns/1ps
`default_nettype none
module bus_mc_log_tb;
    // ------------------------------------------------------------
    // signals and settings
    // ------------------------------------------------------------
    localparam int PS = 2; // shortened prescale, bus clocks per step
    localparam int TW = 2; // shortened timer width
    localparam int OW = 2; // shortened time-out counter width
    localparam int TMO_CYC = PS * 2 * (1 << TW) * (1 << OW); // full count at 1:2
    logic        clock, nrst, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, slvErr, irq;
    logic        instrRetired, exceptionSeen, internalFault, initPin;
    logic        busClockOut, internalFailureOut, busInitSignal;
    mc_log_pkg::busEvt_t fire, pins;
    int          errors, samplesChecked, inits, n;
    typedef struct packed {
        mc_log_pkg::busEvt_t ev; // event raised
        logic [7:0]  a;          // register read back
        logic [31:0] m;          // bits compared
        logic [31:0] e;          // expected bits
    } row_t;
    row_t rows [10] = '{
        '{5'h10, 8'h00, 32'hFFFF_FFFF, 32'h0001_0E0F},
        '{5'h10, 8'h04, 32'hFFFF_FFFF, 32'h0000_0000},
        '{5'h10, 8'h10, 32'h0000_0008, 32'h0000_0008},
        '{5'h08, 8'h00, 32'hFFFF_FFFF, 32'h0010_0E0F},
        '{5'h08, 8'h04, 32'h0000_0400, 32'h0000_0400},
        '{5'h08, 8'h10, 32'h0000_0001, 32'h0000_0001},
        '{5'h04, 8'h00, 32'hFFFF_FFFF, 32'h0020_0E0F},
        '{5'h02, 8'h00, 32'hFFFF_FFFF, 32'h0040_0E0F},
        '{5'h01, 8'h04, 32'h01FF_8000, 32'h0000_8000},
        '{5'h01, 8'h10, 32'h0000_0010, 32'h0000_0010}};
    // ------------------------------------------------------------
    // design, partner, clock
    // ------------------------------------------------------------
    bus_mc_log #(.PRESCALE(PS), .TIMER_W(TW), .TMO_W(OW)) uut (
        .clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .instrRetired, .exceptionSeen, .internalFault, .busInitIn(initPin),
        .reqParPin(pins.reqPar), .hardFailPin(pins.hardFail), .rspParPin(pins.rspPar),
        .dataParPin(pins.dataPar), .corrPin(pins.corr),
        .busClockOut, .internalFailureOut, .busInitSignal, .irq);
    bus_agent_model agent (.clock, .nrst, .fire, .pins);
    always #50 clock = ~clock;
    always @(posedge clock) if (busInitSignal === 1'b1) inits++;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // one apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock) psel <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock) penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        slvErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        samplesChecked++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic pulse(input mc_log_pkg::busEvt_t ev);
        @(posedge clock) fire <= ev;
        @(posedge clock) fire <= '0;
        repeat (10) @(posedge clock);
    endtask : pulse
    // log clear also restores ratio 1:2; sticky events cleared by w1c
    task automatic clearLog;
        apb(1'b1, mc_log_pkg::OFF_CTRL, 32'h0000_0101);
        apb(1'b1, mc_log_pkg::OFF_IRQ_ST, 32'h0000_001F);
    endtask : clearLog
    task automatic results;
        $display("checks %0d, mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    // ------------------------------------------------------------
    // watchdog: whole sequence needs well under 3000 cycles
    // ------------------------------------------------------------
    initial begin
        repeat (8000) @(posedge clock);
        errors++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {clock, nrst, psel, penable, pwrite, exceptionSeen, internalFault, initPin} = '0;
        {paddr, pwdata, fire} = '0;
        {errors, samplesChecked, inits} = '0;
        instrRetired = 1'b1; // retiring keeps the time-out quiet
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        apb(1'b0, mc_log_pkg::OFF_STAT_LO, '0);
        chk(q, mc_log_pkg::STAT_RESET[31:0]);
        apb(1'b0, mc_log_pkg::OFF_CTRL, '0);
        chk(q & 32'h0000_0003, {30'h0, mc_log_pkg::RATIO_RESET});
        apb(1'b0, mc_log_pkg::OFF_TMO, '0);
        chk(q, '0);
        foreach (rows[i]) begin
            clearLog();
            pulse(rows[i].ev);
            apb(1'b0, rows[i].a, '0);
            chk(q & rows[i].m, rows[i].e);
        end
        // a later error is refused while the hard-error entry stands
        clearLog();
        pulse(5'h08);
        pulse(5'h04);
        apb(1'b0, mc_log_pkg::OFF_STAT_LO, '0);
        chk(q, 32'h0010_0E0F);
        // interrupt masked, unmasked, then cleared per bit
        chk(irq, 1'b0);
        apb(1'b1, mc_log_pkg::OFF_IRQ_MSK, 32'h0000_0008);
        repeat (2) @(posedge clock);
        chk(irq, 1'b1);
        apb(1'b1, mc_log_pkg::OFF_IRQ_ST, 32'h0000_0008);
        repeat (2) @(posedge clock);
        chk(irq, 1'b0);
        apb(1'b1, mc_log_pkg::OFF_IRQ_MSK, '0);
        // internal failure
        clearLog();
        @(posedge clock) internalFault <= 1'b1;
        @(posedge clock) internalFault <= 1'b0;
        repeat (4) @(posedge clock);
        chk(internalFailureOut, 1'b1);
        apb(1'b0, mc_log_pkg::OFF_STAT_LO, '0);
        chk(q, 32'h0000_0400);
        apb(1'b0, mc_log_pkg::OFF_STAT_HI, '0);
        chk(q & 32'h0000_0840, 32'h0000_0800);
        clearLog();
        chk(internalFailureOut, 1'b0);
        apb(1'b0, 8'h40, '0);
        chk({slvErr, q}, {1'b1, 32'h0000_0000});
        for (int r = 1; r < 4; r++) begin
            apb(1'b1, mc_log_pkg::OFF_CTRL, 32'(r));
            repeat (10) @(posedge clock);
            n = 0;
            while (busClockOut !== 1'b1 && n < 20) begin
                @(posedge clock);
                n++;
            end
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (busClockOut !== 1'b1 && n < 20);
            chk(n, r + 1);
        end
        clearLog();
        // bus init pin and exceptions, taking turns, keep clearing the counter
        @(posedge clock) instrRetired <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (30) @(posedge clock);
            @(posedge clock) {exceptionSeen, initPin} <= {i[0], !i[0]};
            @(posedge clock) {exceptionSeen, initPin} <= 2'b00;
        end
        chk(inits, 0);
        // free-running timer: first carry lands anywhere in one timer span
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (busInitSignal !== 1'b1 && n < 300);
        chk(n > TMO_CYC - TMO_CYC / (1 << OW) && n < TMO_CYC + 8, 1'b1);
        @(posedge clock) instrRetired <= 1'b1;
        repeat (4) @(posedge clock);
        pulse(5'h04);
        apb(1'b0, mc_log_pkg::OFF_STAT_LO, '0);
        chk(q, 32'h0000_0400);
        apb(1'b0, mc_log_pkg::OFF_STAT_HI, '0);
        chk(q & 32'h0000_0040, 32'h0000_0040);
        results();
    end
endmodule : bus_mc_log_tb
`default_nettype wire
